// >>> fls_pkg.sv
package fls_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_BLOCK_ADDR = 8'h04;
  localparam logic [7:0] REG_TARGET     = 8'h08;
  localparam logic [7:0] REG_DATA       = 8'h0C;
  localparam logic [7:0] REG_STATUS     = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT   = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK   = 8'h18;

  // Control register fields
  localparam int CTRL_OP_LSB    = 0;
  localparam int CTRL_START     = 3;
  localparam int CTRL_SET_WP    = 4;
  localparam int CTRL_CHECK     = 5;
  localparam int CTRL_RETRY_ALL = 6;
  localparam int CTRL_RP_ASSERT = 8;

  // Event bits of the interrupt status and mask registers
  localparam int EV_DONE      = 0;
  localparam int EV_ERASE_ERR = 1;
  localparam int EV_WRITE_ERR = 2;
  localparam int EV_SEQ_ERR   = 3;
  localparam int EV_VPP_LOW   = 4;
  localparam int EV_REFUSED   = 5;
  localparam int EV_W         = 6;

  // Flash status byte fields
  localparam int ST_READY     = 7;
  localparam int ST_ERASE_ERR = 5;
  localparam int ST_WRITE_ERR = 4;
  localparam int ST_VPP_LOW   = 3;

  // Operations
  typedef enum logic [2:0] {
    OP_READ_ARRAY    = 3'b000,
    OP_CLEAR_STATUS  = 3'b001,
    OP_WP_RESET      = 3'b010,
    OP_LOCK_BLOCK    = 3'b011,
    OP_TWO_BYTE      = 3'b100,
    OP_ERASE_ALL     = 3'b101,
    OP_BLOCK_ERASE   = 3'b110,
    OP_RECOVER_ERASE = 3'b111
  } fls_op_e;

  // Flash command bytes
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
  localparam logic [7:0] CMD_CLEAR_STAT  = 8'h50;
  localparam logic [7:0] CMD_WP_RESET    = 8'h47;
  localparam logic [7:0] CMD_WP_SET      = 8'h57;
  localparam logic [7:0] CMD_LOCK_BLOCK  = 8'h77;
  localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
  localparam logic [7:0] CMD_TWO_BYTE    = 8'hFB;
  localparam logic [7:0] CMD_ERASE_ALL   = 8'hA7;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;

  // Addresses
  localparam int ADDR_W = 19;
  localparam int BYTE_SEL_BIT = 10;
  localparam logic [18:0] ADDR_ANY = 19'h0_0000;
  localparam logic [18:0] ADDR_WP  = 19'h0_00FF;

  // Step encoding: kind, address select, data select, constant
  localparam logic [1:0] K_END  = 2'd0;
  localparam logic [1:0] K_WR   = 2'd1;
  localparam logic [1:0] K_POLL = 2'd2;
  localparam logic [1:0] K_OPT  = 2'd3;
  localparam logic [1:0] A_ANY  = 2'd0;
  localparam logic [1:0] A_WP   = 2'd1;
  localparam logic [1:0] A_BA   = 2'd2;
  localparam logic [1:0] A_WA   = 2'd3;
  localparam logic [1:0] D_CONST  = 2'd0;
  localparam logic [1:0] D_FIRST  = 2'd1;
  localparam logic [1:0] D_SECOND = 2'd2;
  localparam logic [1:0] D_ERASE  = 2'd3;

  // Bus cycle timing
  localparam int CLK_NS      = 8;
  localparam int T_SETUP_NS  = 20;
  localparam int T_STROBE_NS = 100;
  localparam int T_RECOV_NS  = 50;
  localparam int SETUP_CYC   = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC  = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOV_CYC   = (T_RECOV_NS + CLK_NS - 1) / CLK_NS;

endpackage : fls_pkg

// >>> fls_cycle.sv
`timescale 1ns/100ps
module fls_cycle (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Request
  input  wire logic        req,
  input  wire logic        req_read,
  input  wire logic [18:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  output logic             done,
  output logic [7:0]       rdata,
  // Flash pins
  output logic [18:0]      flash_addr,
  output logic [7:0]       flash_dq_o,
  input  wire logic [7:0]  flash_dq_i,
  output logic             flash_dq_oe,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n
);

  typedef enum logic [1:0] {
    C_IDLE   = 2'b00,
    C_SETUP  = 2'b01,
    C_STROBE = 2'b10,
    C_RECOV  = 2'b11
  } fls_cyc_e;

  fls_cyc_e   state_q;
  logic [4:0] cnt_q;
  logic       read_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q     <= C_IDLE;
      cnt_q       <= 5'd0;
      read_q      <= 1'b0;
      done        <= 1'b0;
      rdata       <= 8'h00;
      flash_addr  <= 19'h0_0000;
      flash_dq_o  <= 8'h00;
      flash_dq_oe <= 1'b0;
      flash_ce_n  <= 1'b1;
      flash_oe_n  <= 1'b1;
      flash_we_n  <= 1'b1;
    end else begin
      done <= 1'b0;
      unique case (state_q)
        C_IDLE: begin
          if (req) begin
            read_q      <= req_read;
            flash_addr  <= req_addr;
            flash_dq_o  <= req_wdata;
            flash_dq_oe <= !req_read;
            flash_ce_n  <= 1'b0;
            cnt_q       <= 5'(fls_pkg::SETUP_CYC - 1);
            state_q     <= C_SETUP;
          end
        end
        C_SETUP: begin
          if (cnt_q == 5'd0) begin
            flash_oe_n <= !read_q;
            flash_we_n <= read_q;
            cnt_q      <= 5'(fls_pkg::STROBE_CYC - 1);
            state_q    <= C_STROBE;
          end else begin
            cnt_q <= cnt_q - 5'd1;
          end
        end
        C_STROBE: begin
          if (cnt_q == 5'd0) begin
            // Every read ends with CE and OE high so the next one refreshes status
            if (read_q) begin
              rdata <= flash_dq_i;
            end
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_ce_n <= 1'b1;
            cnt_q      <= 5'(fls_pkg::RECOV_CYC - 1);
            state_q    <= C_RECOV;
          end else begin
            cnt_q <= cnt_q - 5'd1;
          end
        end
        C_RECOV: begin
          if (cnt_q == 5'd0) begin
            flash_dq_oe <= 1'b0;
            done        <= 1'b1;
            state_q     <= C_IDLE;
          end else begin
            cnt_q <= cnt_q - 5'd1;
          end
        end
      endcase
    end
  end

endmodule : fls_cycle

// >>> fls_ctrl.sv
// Operation
// - Clear error bits before next program or erase
// - Low voltage: clear, unprotect, retry, reprotect
// - Voltage fine: clear and retry erase (the recover operation here also unprotects with 47H, D0H at 0FFH first)
// - After reset abort: clear, unprotect, retry, reprotect
// - Poll status anywhere, toggling strobes each read
// - Unprotect is 47H then D0H at 0FFH
// - Lock: 77H, D0H at block, poll, protect
// - FBH then byte chosen by address bit 10
// - Full status check per write or sequence
// - Write FFH last to return to array
// - Erase all unlocked: A7H, D0H, poll
// - Retry erase-all or erase blocks one by one
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/100ps
module fls_ctrl (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             irq,
  // Flash pins
  output logic [18:0]      flash_addr,
  output logic [7:0]       flash_dq_o,
  input  wire logic [7:0]  flash_dq_i,
  output logic             flash_dq_oe,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  output logic             deep_powerdown_reset_n
);

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_FETCH = 3'b001,
    S_WAIT  = 3'b010,
    S_CHECK = 3'b011,
    S_CWAIT = 3'b100,
    S_DONE  = 3'b101
  } fls_seq_e;

  // Step table: {kind, address select, data select, constant}
  function automatic logic [13:0] fls_step(input logic [2:0] op, input logic [3:0] idx);
    logic [13:0] s;
    s = {fls_pkg::K_END, fls_pkg::A_ANY, fls_pkg::D_CONST, 8'h00};
    unique case (op)
      fls_pkg::OP_READ_ARRAY: begin
        if (idx == 4'd0) s = {fls_pkg::K_WR, fls_pkg::A_ANY, fls_pkg::D_CONST,
                               fls_pkg::CMD_READ_ARRAY};
      end
      fls_pkg::OP_CLEAR_STATUS: begin
        if (idx == 4'd0) s = {fls_pkg::K_WR, fls_pkg::A_ANY, fls_pkg::D_CONST,
                               fls_pkg::CMD_CLEAR_STAT};
      end
      fls_pkg::OP_WP_RESET: begin
        unique case (idx)
          4'd0: s = {fls_pkg::K_WR, fls_pkg::A_ANY, fls_pkg::D_CONST, fls_pkg::CMD_WP_RESET};
          4'd1: s = {fls_pkg::K_WR, fls_pkg::A_WP, fls_pkg::D_CONST, fls_pkg::CMD_CONFIRM};
          4'd2: s = {fls_pkg::K_POLL, fls_pkg::A_ANY, fls_pkg::D_CONST, 8'h00};
          default: ;
        endcase
      end
      fls_pkg::OP_LOCK_BLOCK: begin
        unique case (idx)
          4'd0: s = {fls_pkg::K_WR, fls_pkg::A_ANY, fls_pkg::D_CONST, fls_pkg::CMD_LOCK_BLOCK};
          4'd1: s = {fls_pkg::K_WR, fls_pkg::A_BA, fls_pkg::D_CONST, fls_pkg::CMD_CONFIRM};
          4'd2: s = {fls_pkg::K_POLL, fls_pkg::A_ANY, fls_pkg::D_CONST, 8'h00};
          // Protect set reloads the real lock bits
          4'd3: s = {fls_pkg::K_WR, fls_pkg::A_ANY, fls_pkg::D_CONST, fls_pkg::CMD_WP_SET};
          4'd4: s = {fls_pkg::K_WR, fls_pkg::A_WP, fls_pkg::D_CONST, fls_pkg::CMD_CONFIRM};
          4'd5: s = {fls_pkg::K_POLL, fls_pkg::A_ANY, fls_pkg::D_CONST, 8'h00};
          default: ;
        endcase
      end
      fls_pkg::OP_TWO_BYTE: begin
        unique case (idx)
          4'd0: s = {fls_pkg::K_POLL, fls_pkg::A_ANY, fls_pkg::D_CONST, 8'h00};
          4'd1: s = {fls_pkg::K_WR, fls_pkg::A_ANY, fls_pkg::D_CONST, fls_pkg::CMD_TWO_BYTE};
          4'd2: s = {fls_pkg::K_WR, fls_pkg::A_WA, fls_pkg::D_FIRST, 8'h00};
          4'd3: s = {fls_pkg::K_WR, fls_pkg::A_WA, fls_pkg::D_SECOND, 8'h00};
          4'd4: s = {fls_pkg::K_POLL, fls_pkg::A_ANY, fls_pkg::D_CONST, 8'h00};
          default: ;
        endcase
      end
      fls_pkg::OP_ERASE_ALL: begin
        unique case (idx)
          4'd0: s = {fls_pkg::K_WR, fls_pkg::A_ANY, fls_pkg::D_CONST, fls_pkg::CMD_ERASE_ALL};
          4'd1: s = {fls_pkg::K_WR, fls_pkg::A_ANY, fls_pkg::D_CONST, fls_pkg::CMD_CONFIRM};
          4'd2: s = {fls_pkg::K_POLL, fls_pkg::A_ANY, fls_pkg::D_CONST, 8'h00};
          default: ;
        endcase
      end
      fls_pkg::OP_BLOCK_ERASE: begin
        unique case (idx)
          4'd0: s = {fls_pkg::K_WR, fls_pkg::A_ANY, fls_pkg::D_CONST, fls_pkg::CMD_BLOCK_ERASE};
          4'd1: s = {fls_pkg::K_WR, fls_pkg::A_BA, fls_pkg::D_CONST, fls_pkg::CMD_CONFIRM};
          4'd2: s = {fls_pkg::K_POLL, fls_pkg::A_ANY, fls_pkg::D_CONST, 8'h00};
          default: ;
        endcase
      end
      fls_pkg::OP_RECOVER_ERASE: begin
        unique case (idx)
          4'd0: s = {fls_pkg::K_WR, fls_pkg::A_ANY, fls_pkg::D_CONST, fls_pkg::CMD_CLEAR_STAT};
          4'd1: s = {fls_pkg::K_WR, fls_pkg::A_ANY, fls_pkg::D_CONST, fls_pkg::CMD_WP_RESET};
          4'd2: s = {fls_pkg::K_WR, fls_pkg::A_WP, fls_pkg::D_CONST, fls_pkg::CMD_CONFIRM};
          4'd3: s = {fls_pkg::K_POLL, fls_pkg::A_ANY, fls_pkg::D_CONST, 8'h00};
          4'd4: s = {fls_pkg::K_WR, fls_pkg::A_ANY, fls_pkg::D_ERASE, 8'h00};
          4'd5: s = {fls_pkg::K_WR, fls_pkg::A_BA, fls_pkg::D_CONST, fls_pkg::CMD_CONFIRM};
          4'd6: s = {fls_pkg::K_POLL, fls_pkg::A_ANY, fls_pkg::D_CONST, 8'h00};
          4'd7: s = {fls_pkg::K_OPT, fls_pkg::A_ANY, fls_pkg::D_CONST, 8'h00};
          4'd8: s = {fls_pkg::K_WR, fls_pkg::A_ANY, fls_pkg::D_CONST, fls_pkg::CMD_WP_SET};
          4'd9: s = {fls_pkg::K_WR, fls_pkg::A_WP, fls_pkg::D_CONST, fls_pkg::CMD_CONFIRM};
          4'd10: s = {fls_pkg::K_POLL, fls_pkg::A_ANY, fls_pkg::D_CONST, 8'h00};
          default: ;
        endcase
      end
      default: ;
    endcase
    return s;
  endfunction : fls_step

  fls_seq_e    state_q;
  logic [2:0]  op_q;
  logic [3:0]  idx_q;
  logic        set_wp_q;
  logic        check_q;
  logic        retry_all_q;
  logic        rp_q;
  logic [18:0] block_q;
  logic [18:0] target_q;
  logic [15:0] data_q;
  logic [7:0]  stat_q;
  logic [fls_pkg::EV_W-1:0] ev_q;
  logic [fls_pkg::EV_W-1:0] mask_q;
  logic [fls_pkg::EV_W-1:0] ev_set;
  logic [31:0] rdata_q;

  logic        cyc_req;
  logic        cyc_read;
  logic [18:0] cyc_addr;
  logic [7:0]  cyc_wdata;
  logic        cyc_done;
  logic [7:0]  cyc_rdata;
  logic [13:0] step;
  logic [1:0]  kind;
  logic        start;
  logic        dev_err;
  logic        needs_clean;
  logic        hi_first;

  assign step     = fls_step(op_q, idx_q);
  assign kind     = step[13:12];
  assign start    = reg_wr && reg_addr == fls_pkg::REG_CTRL && reg_wdata[fls_pkg::CTRL_START];
  assign hi_first = target_q[fls_pkg::BYTE_SEL_BIT];
  // Error bits latched in the flash stay until cleared
  assign dev_err  = stat_q[fls_pkg::ST_VPP_LOW] | stat_q[fls_pkg::ST_WRITE_ERR]
                  | stat_q[fls_pkg::ST_ERASE_ERR];
  assign needs_clean = reg_wdata[2:0] == fls_pkg::OP_LOCK_BLOCK
                    || reg_wdata[2:0] == fls_pkg::OP_TWO_BYTE
                    || reg_wdata[2:0] == fls_pkg::OP_ERASE_ALL
                    || reg_wdata[2:0] == fls_pkg::OP_BLOCK_ERASE;

  // Address and data of the current step
  always_comb begin
    cyc_req   = 1'b0;
    cyc_read  = 1'b0;
    cyc_addr  = fls_pkg::ADDR_ANY;
    cyc_wdata = step[7:0];
    unique case (step[11:10])
      fls_pkg::A_ANY: cyc_addr = fls_pkg::ADDR_ANY;
      fls_pkg::A_WP:  cyc_addr = fls_pkg::ADDR_WP;
      fls_pkg::A_BA:  cyc_addr = block_q;
      fls_pkg::A_WA:  cyc_addr = target_q;
    endcase
    unique case (step[9:8])
      fls_pkg::D_CONST:  cyc_wdata = step[7:0];
      fls_pkg::D_FIRST:  cyc_wdata = hi_first ? data_q[15:8] : data_q[7:0];
      fls_pkg::D_SECOND: cyc_wdata = hi_first ? data_q[7:0] : data_q[15:8];
      fls_pkg::D_ERASE:  cyc_wdata = retry_all_q ? fls_pkg::CMD_ERASE_ALL
                                                 : fls_pkg::CMD_BLOCK_ERASE;
    endcase
    if (state_q == S_FETCH && (kind == fls_pkg::K_WR || kind == fls_pkg::K_POLL)) begin
      cyc_req  = 1'b1;
      cyc_read = kind == fls_pkg::K_POLL;
    end else if (state_q == S_CHECK) begin
      cyc_req  = 1'b1;
      cyc_read = 1'b1;
    end
  end

  // Sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= S_IDLE;
      idx_q   <= 4'd0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (start && !(needs_clean && dev_err)) begin
            idx_q   <= 4'd0;
            state_q <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (kind == fls_pkg::K_END || (kind == fls_pkg::K_OPT && !set_wp_q)) begin
            state_q <= check_q ? S_CHECK : S_DONE;
          end else if (kind == fls_pkg::K_OPT) begin
            idx_q <= idx_q + 4'd1;
          end else begin
            state_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (cyc_done) begin
            // Busy status means read again with a fresh strobe
            if (!(kind == fls_pkg::K_POLL && !cyc_rdata[fls_pkg::ST_READY])) begin
              idx_q <= idx_q + 4'd1;
            end
            state_q <= S_FETCH;
          end
        end
        S_CHECK: state_q <= S_CWAIT;
        S_CWAIT: begin
          if (cyc_done) begin
            state_q <= S_DONE;
          end
        end
        S_DONE:  state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Last status byte seen; its error bits 5:3 cleared with the clear-status command
  always_ff @(posedge clk) begin
    if (rst) begin
      stat_q <= 8'h00;
    end else if (cyc_done && (state_q == S_CWAIT || (state_q == S_WAIT && kind == fls_pkg::K_POLL))) begin
      stat_q <= cyc_rdata;
    end else if (cyc_done && state_q == S_WAIT && cyc_wdata == fls_pkg::CMD_CLEAR_STAT) begin
      stat_q <= {stat_q[7:6], 3'b000, stat_q[2:0]};
    end
  end

  // Events
  always_comb begin
    ev_set = '0;
    ev_set[fls_pkg::EV_REFUSED] = start && state_q == S_IDLE && needs_clean && dev_err;
    if (state_q == S_CWAIT && cyc_done) begin
      // Both error bits together mean a bad command sequence
      ev_set[fls_pkg::EV_SEQ_ERR]   = cyc_rdata[fls_pkg::ST_ERASE_ERR]
                                    & cyc_rdata[fls_pkg::ST_WRITE_ERR];
      ev_set[fls_pkg::EV_ERASE_ERR] = cyc_rdata[fls_pkg::ST_ERASE_ERR]
                                    & !cyc_rdata[fls_pkg::ST_WRITE_ERR];
      ev_set[fls_pkg::EV_WRITE_ERR] = cyc_rdata[fls_pkg::ST_WRITE_ERR]
                                    & !cyc_rdata[fls_pkg::ST_ERASE_ERR];
      // Low voltage tells software which recovery path applies
      ev_set[fls_pkg::EV_VPP_LOW]   = cyc_rdata[fls_pkg::ST_VPP_LOW];
    end
    ev_set[fls_pkg::EV_DONE] = state_q == S_DONE;
  end

  // Control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      op_q        <= fls_pkg::OP_READ_ARRAY;
      set_wp_q    <= 1'b0;
      check_q     <= 1'b0;
      retry_all_q <= 1'b0;
      rp_q        <= 1'b0;
      block_q     <= 19'h0_0000;
      target_q    <= 19'h0_0000;
      data_q      <= 16'h0000;
      mask_q      <= '0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        fls_pkg::REG_CTRL: begin
          // Operation fields held steady while a sequence runs
          if (state_q == S_IDLE) begin
            op_q        <= reg_wdata[2:0];
            set_wp_q    <= reg_wdata[fls_pkg::CTRL_SET_WP];
            check_q     <= reg_wdata[fls_pkg::CTRL_CHECK];
            retry_all_q <= reg_wdata[fls_pkg::CTRL_RETRY_ALL];
          end
          rp_q <= reg_wdata[fls_pkg::CTRL_RP_ASSERT];
        end
        fls_pkg::REG_BLOCK_ADDR: block_q  <= reg_wdata[18:0];
        fls_pkg::REG_TARGET:     target_q <= reg_wdata[18:0];
        fls_pkg::REG_DATA:       data_q   <= reg_wdata[15:0];
        fls_pkg::REG_IRQ_MASK:   mask_q   <= reg_wdata[fls_pkg::EV_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      ev_q <= '0;
    end else if (reg_wr && reg_addr == fls_pkg::REG_IRQ_STAT) begin
      ev_q <= (ev_q & ~reg_wdata[fls_pkg::EV_W-1:0]) | ev_set;
    end else begin
      ev_q <= ev_q | ev_set;
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        fls_pkg::REG_CTRL:       rdata_q <= {23'h00_0000, rp_q, 1'b0, retry_all_q, check_q,
                                             set_wp_q, 1'b0, op_q};
        fls_pkg::REG_BLOCK_ADDR: rdata_q <= {13'h0000, block_q};
        fls_pkg::REG_TARGET:     rdata_q <= {13'h0000, target_q};
        fls_pkg::REG_DATA:       rdata_q <= {16'h0000, data_q};
        fls_pkg::REG_STATUS:     rdata_q <= {16'h0000, stat_q, 7'h00, state_q != S_IDLE};
        fls_pkg::REG_IRQ_STAT:   rdata_q <= {26'h000_0000, ev_q};
        fls_pkg::REG_IRQ_MASK:   rdata_q <= {26'h000_0000, mask_q};
        default:                 rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq       = |(ev_q & mask_q);
  assign deep_powerdown_reset_n = !rp_q;

  fls_cycle u_cycle (
    .clk         (clk),
    .rst         (rst),
    .req         (cyc_req),
    .req_read    (cyc_read),
    .req_addr    (cyc_addr),
    .req_wdata   (cyc_wdata),
    .done        (cyc_done),
    .rdata       (cyc_rdata),
    .flash_addr  (flash_addr),
    .flash_dq_o  (flash_dq_o),
    .flash_dq_i  (flash_dq_i),
    .flash_dq_oe (flash_dq_oe),
    .flash_ce_n  (flash_ce_n),
    .flash_oe_n  (flash_oe_n),
    .flash_we_n  (flash_we_n)
  );

endmodule : fls_ctrl

// >>> fls_checker.sv
`timescale 1ns/100ps
module fls_checker (
  // Clock, reset, register port
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        irq,
  // Flash pins
  input wire logic [18:0] flash_addr,
  input wire logic [7:0]  flash_dq_o,
  input wire logic [7:0]  flash_dq_i,
  input wire logic        flash_dq_oe,
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n,
  input wire logic        deep_powerdown_reset_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] prev_q;
  // Last byte put on the bus, to know which command a confirm closes
  always_ff @(posedge clk) begin
    if (rst) prev_q <= 8'h00;
    else if ($fell(flash_we_n)) prev_q <= flash_dq_o;
  end
  sequence s_low13(x);
    !x [*8] ##1 !x [*5];
  endsequence
  property p_we_width; $fell(flash_we_n) |-> s_low13(flash_we_n) ##1 flash_we_n; endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe width");
  property p_oe_width; $fell(flash_oe_n) |-> s_low13(flash_oe_n) ##1 flash_oe_n; endproperty
  a_oe_width: assert property (p_oe_width) else $error("read strobe width");
  property p_ce_rest; $rose(flash_ce_n) |-> flash_ce_n [*8]; endproperty
  a_ce_rest: assert property (p_ce_rest) else $error("chip enable gap");
  property p_rd_excl; !flash_oe_n |-> !flash_ce_n && flash_we_n && !flash_dq_oe; endproperty
  a_rd_excl: assert property (p_rd_excl) else $error("read cycle pins");
  property p_wr_drive;
    !flash_we_n |-> !flash_ce_n && flash_dq_oe && $stable(flash_addr) && $stable(flash_dq_o);
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write cycle pins");
  property p_wp_addr;
    $fell(flash_we_n) && flash_dq_o == 8'hD0 && (prev_q == 8'h47 || prev_q == 8'h57)
      |-> flash_addr == fls_pkg::ADDR_WP;
  endproperty
  a_wp_addr: assert property (p_wp_addr) else $error("protect confirm address");
  property p_rp;
    reg_wr && reg_addr == fls_pkg::REG_CTRL |=> deep_powerdown_reset_n == !$past(reg_wdata[8]);
  endproperty
  a_rp: assert property (p_rp) else $error("reset pin");
  property p_mask_off;
    reg_wr && reg_addr == fls_pkg::REG_IRQ_MASK && reg_wdata[5:0] == 6'h00 |=> !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("masked irq");
endmodule : fls_checker
bind fls_ctrl fls_checker u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq(irq), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o), .flash_dq_i(flash_dq_i),
  .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
  .flash_we_n(flash_we_n), .deep_powerdown_reset_n(deep_powerdown_reset_n));

// >>> fls_flash_model.sv
`timescale 1ns/100ps
module fls_flash_model (
  // Flash pins
  input  wire logic [18:0] addr,
  input  wire logic [7:0]  dq_in,
  output logic [7:0]       dq_out,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        rp_n,
  // Status bits that fail the next erase
  input  wire logic [7:0]  fault
);
  logic [7:0]  stat = 8'h00;
  logic [7:0]  shown = 8'h80;
  logic [7:0]  cmd = 8'hFF;
  logic [15:0] dreg = 16'h0000;
  logic        locked = 1'b1;
  int          busy = 0;
  int          tw = 0;
  logic [26:0] wlog[$];
  // No pull on the bus: idle shows the inverse
  assign dq_out = (!ce_n && !oe_n) ? shown : ~shown;
  always @(negedge oe_n) shown = {busy == 0, stat[6:0]};
  always @(posedge oe_n) if (busy > 0) busy--;
  always @(negedge rp_n) locked = 1'b1;
  always @(negedge we_n) begin
    wlog.push_back({addr, dq_in});
    if (tw > 0) begin
      if (addr[10] ^ (tw == 2)) dreg[15:8] = dq_in;
      else dreg[7:0] = dq_in;
      tw = (tw == 2) ? 0 : 2;
      if (tw == 0) busy = 2;
    end else if (dq_in == 8'hD0) begin
      if (cmd == 8'h47 || cmd == 8'h57) locked = 1'b0;
      if (cmd == 8'h20 || cmd == 8'hA7) stat[5:3] = stat[5:3] | fault[5:3];
      busy = 3;
      cmd = 8'hFF;
    end else begin
      if (dq_in == 8'h50) stat[5:3] = 3'b000;
      if (dq_in == 8'hFB) tw = 1;
      cmd = dq_in;
    end
  end
endmodule : fls_flash_model

// >>> tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic        clk, rst, reg_wr, reg_rd, irq, dq_oe, ce_n, oe_n, we_n, rp_n;
  logic [7:0]  reg_addr, dq_o, dq_m, fault;
  logic [31:0] reg_wdata, reg_rdata, v, lf;
  logic [18:0] fa, ba, ta;
  logic [15:0] wd;
  logic [26:0] exq[$];
  int          num_errors, n_compared;
  wire  [7:0]  dq_w = dq_oe ? dq_o : dq_m;
  fls_ctrl uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .flash_addr(fa),
    .flash_dq_o(dq_o), .flash_dq_i(dq_w), .flash_dq_oe(dq_oe), .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .deep_powerdown_reset_n(rp_n));
  fls_flash_model dev (.addr(fa), .dq_in(dq_w), .dq_out(dq_m), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .rp_n(rp_n), .fault(fault));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  function automatic logic [7:0] pick(input logic [15:0] w, input logic hi);
    return hi ? w[15:8] : w[7:0];
  endfunction : pick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  // Start an operation and poll busy; a hang ends the poll after 4000 status reads
  task automatic run(input logic [31:0] c);
    wr(fls_pkg::REG_CTRL, c | 32'h0000_0008);
    for (int i = 0; i < 4000; i++) begin
      rd(fls_pkg::REG_STATUS);
      if (v[0] === 1'b0) break;
    end
  endtask : run
  task automatic ex(input logic [18:0] a, input logic [7:0] d);
    exq.push_back({a, d});
  endtask : ex
  task automatic cmp();
    chk(dev.wlog.size(), exq.size());
    foreach (exq[i]) chk({5'h00, dev.wlog[i]}, {5'h00, exq[i]});
    dev.wlog.delete();
    exq.delete();
  endtask : cmp
  task automatic conclude();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #700_000;
    num_errors++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    fault = 8'h00;
    lf = 32'h0001_266B;
    num_errors = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(8'h20);
    chk(v, 32'h0000_0000);
    wr(fls_pkg::REG_IRQ_MASK, 32'h0000_003F);
    run(fls_pkg::OP_READ_ARRAY);
    ex(19'h0_0000, 8'hFF);
    cmp();
    run(fls_pkg::OP_WP_RESET);
    ex(19'h0_0000, 8'h47);
    ex(19'h0_00FF, 8'hD0);
    cmp();
    lf = nx(lf);
    ba = lf[18:0];
    wr(fls_pkg::REG_BLOCK_ADDR, {13'h0000, ba});
    run(fls_pkg::OP_LOCK_BLOCK);
    ex(19'h0_0000, 8'h77);
    ex(ba, 8'hD0);
    ex(19'h0_0000, 8'h57);
    ex(19'h0_00FF, 8'hD0);
    cmp();
    for (int k = 0; k < 2; k++) begin
      lf = nx(lf);
      ta = {lf[18:11], k[0], lf[9:0]};
      wd = lf[31:16];
      wr(fls_pkg::REG_TARGET, {13'h0000, ta});
      wr(fls_pkg::REG_DATA, {16'h0000, wd});
      run(fls_pkg::OP_TWO_BYTE);
      ex(19'h0_0000, 8'hFB);
      ex(ta, pick(wd, ta[10]));
      ex(ta, pick(wd, !ta[10]));
      cmp();
      chk({16'h0000, dev.dreg}, {16'h0000, wd});
    end
    run(fls_pkg::OP_ERASE_ALL);
    ex(19'h0_0000, 8'hA7);
    ex(19'h0_0000, 8'hD0);
    cmp();
    fault = 8'h38;
    run(32'h0000_0026);
    ex(19'h0_0000, 8'h20);
    ex(ba, 8'hD0);
    cmp();
    rd(fls_pkg::REG_IRQ_STAT);
    chk(v & 32'h0000_0018, 32'h0000_0018);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    // Pending error bits must block the next erase
    run(fls_pkg::OP_BLOCK_ERASE);
    cmp();
    rd(fls_pkg::REG_IRQ_STAT);
    chk({31'h0000_0000, v[5]}, 32'h0000_0001);
    wr(fls_pkg::REG_IRQ_MASK, 32'h0000_0000);
    #1 chk({31'h0000_0000, irq}, 32'h0000_0000);
    wr(fls_pkg::REG_IRQ_STAT, 32'h0000_003F);
    rd(fls_pkg::REG_IRQ_STAT);
    chk(v, 32'h0000_0000);
    wr(fls_pkg::REG_IRQ_MASK, 32'h0000_003F);
    fault = 8'h00;
    for (int k = 0; k < 2; k++) begin
      run(k ? 32'h0000_0047 : 32'h0000_0017);
      ex(19'h0_0000, 8'h50);
      ex(19'h0_0000, 8'h47);
      ex(19'h0_00FF, 8'hD0);
      ex(19'h0_0000, k ? 8'hA7 : 8'h20);
      ex(ba, 8'hD0);
      if (k == 0) ex(19'h0_0000, 8'h57);
      if (k == 0) ex(19'h0_00FF, 8'hD0);
      cmp();
      rd(fls_pkg::REG_STATUS);
      chk(v & 32'h0000_3800, 32'h0000_0000);
    end
    wr(fls_pkg::REG_CTRL, 32'h0000_0100);
    #1 chk({31'h0000_0000, dev.locked}, 32'h0000_0001);
    wr(fls_pkg::REG_CTRL, 32'h0000_0000);
    run(fls_pkg::OP_CLEAR_STATUS);
    ex(19'h0_0000, 8'h50);
    cmp();
    conclude();
  end
endmodule : tb_top
